// [fpl_top.sv]
// Calibration and pull-in limit registers with the clamp of the main digital pll
module fpl_top
  import fpl_pkg::*;
#(
  parameter int unsigned LIMIT_SCALE = 4
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_rd_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output logic reg_unmapped_out,
  input wire fpl_off_t ref_offset_in,
  output fpl_off_t trk_offset_out,
  output logic at_limit_out,
  output fpl_off_t cal_offset_out,
  output fpl_limit_t limit_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  logic sel_cal_lo;
  logic sel_cal_hi;
  logic sel_lim_lo;
  logic sel_lim_hi;
  logic sel_any;

  always_comb begin
    sel_cal_lo = (reg_addr_in == ADDR_CAL_LO);
    sel_cal_hi = (reg_addr_in == ADDR_CAL_HI);
    sel_lim_lo = (reg_addr_in == ADDR_LIM_LO);
    sel_lim_hi = (reg_addr_in == ADDR_LIM_HI);
    sel_any = sel_cal_lo | sel_cal_hi | sel_lim_lo | sel_lim_hi;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  logic [7:0] cal_lo_d;
  logic [7:0] cal_lo_q;
  logic [7:0] cal_hi_d;
  logic [7:0] cal_hi_q;
  logic [7:0] lim_lo_d;
  logic [7:0] lim_lo_q;
  logic [LIM_HI_W-1:0] lim_hi_d;
  logic [LIM_HI_W-1:0] lim_hi_q;
  fpl_off_t cal_off_d;
  fpl_off_t cal_off_q;

  always_comb begin
    cal_lo_d = cal_lo_q;
    cal_hi_d = cal_hi_q;
    lim_lo_d = lim_lo_q;
    lim_hi_d = lim_hi_q;
    if (reg_wr_in) begin
      if (sel_cal_lo) begin
        cal_lo_d = reg_wdata_in; // [RULE8]
      end
      if (sel_cal_hi) begin
        cal_hi_d = reg_wdata_in; // [RULE8]
      end
      if (sel_lim_lo) begin
        lim_lo_d = reg_wdata_in; // [RULE3]
      end
      if (sel_lim_hi) begin
        // Only the two limit bits are stored; the rest read as zero
        lim_hi_d = reg_wdata_in[LIM_HI_W-1:0]; // [RULE7]
      end
    end
    // Unsigned word, shifted so the zero-ppm word gives zero
    cal_off_d = OFF_W'({cal_hi_d, cal_lo_d}) - OFF_W'(CAL_ZERO_WORD); // [RULE2]
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cal_lo_q <= RST_CAL_LO;
      cal_hi_q <= RST_CAL_HI;
      lim_lo_q <= RST_LIM_LO; // [RULE3]
      lim_hi_q <= RST_LIM_HI[LIM_HI_W-1:0]; // [RULE7]
      cal_off_q <= '0;
    end else begin
      cal_lo_q <= cal_lo_d;
      cal_hi_q <= cal_hi_d;
      lim_lo_q <= lim_lo_d;
      lim_hi_q <= lim_hi_d;
      // Built from the next values so the offset moves with the byte
      cal_off_q <= cal_off_d; // [RULE1]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-back

  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] rdata_q;
  logic rvalid_d;
  logic rvalid_q;
  logic unmapped_d;
  logic unmapped_q;

  always_comb begin
    rdata_d = rdata_q;
    rvalid_d = reg_rd_in;
    unmapped_d = (reg_rd_in | reg_wr_in) & ~sel_any;
    if (reg_rd_in) begin
      // A read in the cycle of a write returns the value before it
      if (sel_cal_lo) begin
        rdata_d = cal_lo_q; // [RULE8]
      end else if (sel_cal_hi) begin
        rdata_d = cal_hi_q;
      end else if (sel_lim_lo) begin
        rdata_d = lim_lo_q;
      end else if (sel_lim_hi) begin
        rdata_d = {{(DATA_W-LIM_HI_W){1'b0}}, lim_hi_q}; // [RULE7]
      end else begin
        rdata_d = RD_UNMAPPED;
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_q <= '0;
      rvalid_q <= 1'b0;
      unmapped_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      unmapped_q <= unmapped_d;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign reg_rvalid_out = rvalid_q;
  assign reg_unmapped_out = unmapped_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pull-in clamp

  fpl_clamp_if lnk();

  // Ten-bit limit: companion bits on top of the low byte
  assign lnk.limit = {lim_hi_q, lim_lo_q}; // [RULE6]
  assign lnk.cal_off = cal_off_q; // [RULE5]
  assign lnk.ref_off = ref_offset_in;

  fpl_clamp #(
    .SCALE(LIMIT_SCALE)
  ) u_clamp (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .lnk(lnk)
  );

  assign trk_offset_out = lnk.trk_off;
  assign at_limit_out = lnk.at_limit; // [RULE4]
  assign cal_offset_out = cal_off_q;
  assign limit_out = lnk.limit;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_cal_word;
    @(posedge clk_in) disable iff (!reset_n_in)
    ##1 cal_offset_out == OFF_W'({cal_hi_q, cal_lo_q}) - OFF_W'(CAL_ZERO_WORD);
  endproperty
  a_cal_word: assert property (p_cal_word) else $error("calibration offset mismatch"); // [RULE2]

  property p_cal_floor;
    @(posedge clk_in) disable iff (!reset_n_in)
    ({cal_hi_q, cal_lo_q} == 16'h0000) && $past(reset_n_in)
      |-> cal_offset_out == -OFF_W'(CAL_ZERO_WORD);
  endproperty
  a_cal_floor: assert property (p_cal_floor) else $error("calibration floor wrong"); // [RULE1]

  sequence s_lim_lo_write;
    reg_wr_in && sel_lim_lo;
  endsequence

  property p_lim_lo_write;
    @(posedge clk_in) disable iff (!reset_n_in)
    s_lim_lo_write |=> lim_lo_q == $past(reg_wdata_in);
  endproperty
  a_lim_lo_write: assert property (p_lim_lo_write) else $error("limit byte not stored"); // [RULE3]

  sequence s_cal_hi_write;
    reg_wr_in && sel_cal_hi;
  endsequence

  property p_cal_effect;
    @(posedge clk_in) disable iff (!reset_n_in)
    s_cal_hi_write |=> cal_offset_out[CAL_W:8] == 9'({1'b0, $past(reg_wdata_in)}) - 9'h099
      || cal_offset_out[CAL_W:8] == 9'({1'b0, $past(reg_wdata_in)}) - 9'h09A;
  endproperty
  a_cal_effect: assert property (p_cal_effect) else $error("calibration write too late"); // [RULE8]

  sequence s_read_lim_lo;
    reg_rd_in && sel_lim_lo;
  endsequence

  property p_readback;
    @(posedge clk_in) disable iff (!reset_n_in)
    s_read_lim_lo |=> reg_rvalid_out && (reg_rdata_out == $past(lim_lo_q));
  endproperty
  a_readback: assert property (p_readback) else $error("read-back wrong"); // [RULE8]

  property p_hi_read;
    @(posedge clk_in) disable iff (!reset_n_in)
    (reg_rd_in && sel_lim_hi) |=> reg_rdata_out == {6'h00, $past(lim_hi_q)};
  endproperty
  a_hi_read: assert property (p_hi_read) else $error("upper limit read wrong"); // [RULE7]

  property p_limit_join;
    @(posedge clk_in) disable iff (!reset_n_in)
    limit_out[LIMIT_W-1:8] == lim_hi_q && limit_out[7:0] == lim_lo_q;
  endproperty
  a_limit_join: assert property (p_limit_join) else $error("limit word misjoined"); // [RULE6]

  property p_zero_limit;
    @(posedge clk_in) disable iff (!reset_n_in)
    (limit_out == 10'h000 && ref_offset_in != cal_offset_out) |=> at_limit_out
      && trk_offset_out == 20'h00000;
  endproperty
  a_zero_limit: assert property (p_zero_limit) else $error("zero limit did not clamp"); // [RULE4]
endmodule

// [fpl_pkg.sv]
// Constants and types for the crystal calibration and pull-in limit block
// What this block does
// RULE1 - Calibration reaches about minus 771 ppm
// RULE2 - Offset is (word minus 39321) times step
// RULE3 - Limit low byte read-write, resets all ones
// RULE4 - Offset beyond limit is clamped, not tracked
// RULE5 - Limit judged against the calibrated crystal
// RULE6 - Ten-bit unsigned limit, symmetric both directions
// RULE7 - Limit top bits separate register, resets 03
// RULE8 - Writes act next cycle, reads return stored
package fpl_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CAL_W = 16;
  localparam int unsigned LIMIT_W = 10;
  localparam int unsigned LIM_HI_W = 2;
  localparam int unsigned OFF_W = 20;
  localparam logic [7:0] ADDR_CAL_LO = 8'h3C;
  localparam logic [7:0] ADDR_CAL_HI = 8'h3D;
  localparam logic [7:0] ADDR_LIM_LO = 8'h41;
  localparam logic [7:0] ADDR_LIM_HI = 8'h42;
  localparam logic [7:0] RST_CAL_LO = 8'h99;
  localparam logic [7:0] RST_CAL_HI = 8'h99;
  localparam logic [7:0] RST_LIM_LO = 8'hFF;
  localparam logic [7:0] RST_LIM_HI = 8'h03;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // Word that means zero ppm, 39321 decimal
  localparam logic [CAL_W-1:0] CAL_ZERO_WORD = 16'h9999;
  localparam real CAL_PPM_PER_STEP = 0.0196229;
  localparam int CAL_MIN_PPM = -771;
  typedef logic signed [OFF_W-1:0] fpl_off_t;
  typedef logic [LIMIT_W-1:0] fpl_limit_t;
endpackage

// [fpl_clamp_if.sv]
// Carrier between the register file and the pull-in clamp
interface fpl_clamp_if
  import fpl_pkg::*;
  ();
  fpl_limit_t limit;
  fpl_off_t cal_off;
  fpl_off_t ref_off;
  fpl_off_t trk_off;
  logic at_limit;
  modport cfg(output limit, output cal_off, output ref_off, input trk_off, input at_limit);
  modport clamp(input limit, input cal_off, input ref_off, output trk_off, output at_limit);
endinterface

// [fpl_clamp.sv]
// Symmetric pull-in clamp of the tracked offset around the calibrated crystal
module fpl_clamp
  import fpl_pkg::*;
#(
  parameter int unsigned SCALE = 4
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  fpl_clamp_if.clamp lnk
);
  fpl_off_t rel;
  fpl_off_t bound;
  fpl_off_t trk_d;
  fpl_off_t trk_q;
  logic lim_d;
  logic lim_q;

  always_comb begin
    // Offset seen against the calibrated crystal, not the raw one
    rel = lnk.ref_off - lnk.cal_off; // [RULE5]
    bound = OFF_W'(lnk.limit) * OFF_W'(SCALE); // [RULE6]
    trk_d = rel;
    lim_d = 1'b0;
    if (rel > bound) begin
      trk_d = bound; // [RULE4]
      lim_d = 1'b1;
    end else if (rel < -bound) begin
      trk_d = -bound; // [RULE6]
      lim_d = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      trk_q <= '0;
      lim_q <= 1'b0;
    end else begin
      trk_q <= trk_d;
      lim_q <= lim_d;
    end
  end

  assign lnk.trk_off = trk_q;
  assign lnk.at_limit = lim_q;

  property p_clamp_high;
    @(posedge clk_in) disable iff (!reset_n_in)
    (rel > bound) |=> (trk_q == $past(bound)) && lim_q;
  endproperty
  a_clamp_high: assert property (p_clamp_high) else $error("high offset not clamped"); // [RULE4]

  property p_clamp_low;
    @(posedge clk_in) disable iff (!reset_n_in)
    (rel < -bound) |=> (trk_q == -$past(bound)) && lim_q;
  endproperty
  a_clamp_low: assert property (p_clamp_low) else $error("low offset not clamped"); // [RULE6]

  property p_track_inside;
    @(posedge clk_in) disable iff (!reset_n_in)
    (rel <= bound && rel >= -bound)
      |=> (trk_q == $past(lnk.ref_off) - $past(lnk.cal_off)) && !lim_q;
  endproperty
  a_track_inside: assert property (p_track_inside) else $error("offset inside limit altered"); // [RULE5]
endmodule

// [fpl_host.sv]
// Host model that drives the parallel register strobe port of the block
module fpl_host
  import fpl_pkg::*;
(
  input wire logic clk_in,
  output logic [ADDR_W-1:0] addr_out,
  output logic wr_out,
  output logic [DATA_W-1:0] wdata_out,
  output logic rd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // One strobe per access, held over exactly one rising edge
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = w;
    rd_out = !w;
    @(negedge clk_in);
    wr_out = 1'b0;
    rd_out = 1'b0;
    // Released lines must not keep a value the block could latch by mistake
    addr_out = ~a;
    wdata_out = ~d;
  endtask
endmodule

// [tb_top.sv]
// Self-checking bench for the calibration and pull-in limit block
module tb_top
  import fpl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 4;
  logic clk_in, reset_n_in, wr, rd, rvalid, unm, at_lim;
  logic [7:0] addr, wdata, rdata;
  fpl_off_t ref_off, trk, cal_off;
  fpl_limit_t lim;
  int n_fail = 0;
  int check_count = 0;
  logic [8:0] exp_q[$];
  logic [7:0] c_lo = 8'h99, c_hi = 8'h99, l_lo = 8'hFF, l_hi = 8'h03;
  int cal_e, b;
  fpl_host host (.clk_in(clk_in), .addr_out(addr), .wr_out(wr), .wdata_out(wdata),
    .rd_out(rd));
  fpl_top #(.LIMIT_SCALE(SC)) dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .reg_unmapped_out(unm),
    .ref_offset_in(ref_off), .trk_offset_out(trk), .at_limit_out(at_lim),
    .cal_offset_out(cal_off), .limit_out(lim));
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s exp %0h got %0h", nm, e, g);
    end
  endtask
  // Read answer: unmapped flag above the data byte
  task automatic chk_rd(input logic [8:0] e, input logic [8:0] g);
    chk("rdata", 32'(e), 32'(g));
  endtask
  // Clamp answer: tracked offset and the limit flag together
  task automatic chk_clamp(input int e, input logic e_lim);
    chk("trk", 32'(e), 32'(trk));
    chk("at_limit", 32'(e_lim), 32'(at_lim));
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic rd_exp(input logic [7:0] a, input logic [8:0] e);
    exp_q.push_back(e);
    host.access(1'b0, a, 8'h00);
  endtask
  // Keeps the local model of the four bytes in step with each write
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    host.access(1'b1, a, d);
    if (a == ADDR_CAL_LO) c_lo = d;
    if (a == ADDR_CAL_HI) c_hi = d;
    if (a == ADDR_LIM_LO) l_lo = d;
    if (a == ADDR_LIM_HI) l_hi = {6'h00, d[1:0]};
    cal_e = int'({c_hi, c_lo}) - 39321;
    b = int'({l_hi[1:0], l_lo}) * SC;
    chk("cal", 32'(cal_e), 32'(cal_off));
    chk("limit", 32'(b / SC), 32'(lim));
  endtask
  task automatic clamp(input int rel);
    int e;
    @(negedge clk_in);
    ref_off = OFF_W'(cal_e + rel);
    @(negedge clk_in);
    e = (rel > b) ? b : (rel < -b) ? -b : rel;
    chk_clamp(e, rel > b || rel < -b);
  endtask
  always @(negedge clk_in) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0)
        chk("rvalid", 32'h0, 32'h1);
      else
        chk_rd(exp_q.pop_front(), {unm, rdata});
    end
  end
  initial begin
    // Far beyond the scripted run, well inside the cycle budget
    #1000000;
    n_fail++;
    $display("mismatch timeout exp done got hang");
    finish_test();
  end
  initial begin
    reset_n_in = 1'b0;
    ref_off = '0;
    void'($urandom(32'h0B5D0843));
    repeat (4) @(negedge clk_in);
    reset_n_in = 1'b1;
    cal_e = 0;
    b = 1023 * SC;
    chk("cal_rst", 32'h0, 32'(cal_off));
    chk("lim_rst", 32'h3FF, 32'(lim));
    rd_exp(ADDR_CAL_LO, 9'h099);
    rd_exp(ADDR_CAL_HI, 9'h099);
    rd_exp(ADDR_LIM_LO, 9'h0FF);
    rd_exp(ADDR_LIM_HI, 9'h003);
    clamp(b + 1);
    for (int i = 0; i < 6; i++) begin
      // First pass reaches the lowest calibration, second a zero limit
      wr_reg(ADDR_CAL_LO, (i == 0) ? 8'h00 : 8'($urandom));
      wr_reg(ADDR_CAL_HI, (i == 0) ? 8'h00 : 8'($urandom));
      if (i == 0) chk("cal_min", 32'(-39321), 32'(cal_off));
      wr_reg(ADDR_LIM_LO, (i == 1) ? 8'h00 : 8'($urandom));
      wr_reg(ADDR_LIM_HI, (i == 1) ? 8'hFC : 8'($urandom));
      rd_exp(ADDR_LIM_HI, {1'b0, l_hi});
      rd_exp(ADDR_LIM_LO, {1'b0, l_lo});
      rd_exp(ADDR_CAL_HI, {1'b0, c_hi});
      clamp(b);
      clamp(-b);
      clamp(b + 1);
      clamp(-b - 1);
      repeat (4) clamp(int'($urandom_range(2 * b + 400)) - b - 200);
    end
    // A second reset in mid-run must bring back every default
    @(negedge clk_in);
    reset_n_in = 1'b0;
    @(negedge clk_in);
    chk("trk_rst", 32'h0, 32'(trk));
    chk("at_limit_rst", 32'h0, 32'(at_lim));
    reset_n_in = 1'b1;
    c_lo = RST_CAL_LO;
    c_hi = RST_CAL_HI;
    l_lo = RST_LIM_LO;
    l_hi = RST_LIM_HI;
    cal_e = 0;
    b = 1023 * SC;
    chk("cal_rst2", 32'h0, 32'(cal_off));
    chk("lim_rst2", 32'h3FF, 32'(lim));
    rd_exp(ADDR_LIM_HI, 9'h003);
    rd_exp(ADDR_LIM_LO, 9'h0FF);
    rd_exp(ADDR_CAL_HI, 9'h099);
    clamp(-b - 1);
    host.access(1'b1, 8'h50, 8'hA5);
    chk("unmapped_wr", 32'h1, 32'(unm));
    rd_exp(8'h50, 9'h100);
    rd_exp(ADDR_CAL_LO, {1'b0, c_lo});
    repeat (3) @(negedge clk_in);
    chk("queue", 32'h0, 32'(exp_q.size()));
    finish_test();
  end
endmodule
